// *** sqtd_pkg.sv ***
// constants shared by the squib test and diagnostic command decoder
`default_nettype none
package sqtd_pkg;

	// ************************************************************
	// command codes and fixed answers
	// ************************************************************
	localparam logic [7:0] CMD_UNLOCK_CNT2 = 8'h81;
	localparam logic [7:0] CMD_UNLOCK_HS = 8'h82;
	localparam logic [7:0] CMD_UNLOCK_LS = 8'h83;
	localparam logic [7:0] CMD_RSVD_LO = 8'h90;
	localparam logic [7:0] CMD_RSVD_HI = 8'h93;
	localparam logic [7:0] CMD_LINK_CHECK = 8'h96;
	localparam logic [7:0] RESP_LINK_CHECK = 8'h69;
	localparam logic [7:0] CMD_RES_DIAG = 8'hC8;
	localparam logic [7:0] RESP_NOP = 8'h00;
	localparam logic [3:0] NIB_HS_TEST = 4'h1;
	localparam logic [3:0] NIB_LS_TEST = 4'h2;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// ************************************************************
	// resistor diagnostic answer layout
	// ************************************************************
	localparam int DG_FEN1 = 0;
	localparam int DG_FEN2 = 1;
	localparam int DG_LATCH1 = 2;
	localparam int DG_LATCH2 = 3;
	localparam int DG_RDIAG_OK = 4;
	localparam int DG_RLIM1_OK = 5;
	localparam int DG_RLIM2_OK = 6;
	localparam int DG_ONE = 7;

	// ************************************************************
	// reset values and link framing
	// ************************************************************
	localparam logic [7:0] FIRE_ENABLE2_COUNT_RST = 8'h00;
	localparam logic [3:0] SPI_BITS = 4'h8;

	typedef enum logic [1:0] {ST_IDLE, ST_CNT, ST_HS, ST_LS} sqtd_seq_t;
	typedef enum logic [1:0] {RM_FIX, RM_HS, RM_LS, RM_DIAG} sqtd_resp_t;

endpackage : sqtd_pkg
`default_nettype wire

// *** sqtd_sync_if.sv ***
// carrier between the decoder and its input synchroniser
`default_nettype none
interface sqtd_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport src (output raw, input clean);
	modport sync (input raw, output clean);
endinterface : sqtd_sync_if
`default_nettype wire

// *** sqtd_sync.sv ***
// two-stage synchroniser for pins and link-domain levels
`default_nettype none
module sqtd_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	sqtd_sync_if.sync port
);
	logic [W-1:0] meta;
	logic [W-1:0] stage2;

	// first stage feeds only the second, nothing else looks at it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta <= '0;
			stage2 <= '0;
		end else begin
			meta <= port.raw;
			stage2 <= meta;
		end
	end

	assign port.clean = stage2;

	// a carrier of no bits cannot be built, so refuse it at elaboration
	if (W < 1) begin : g_bad_width
		$error("sqtd_sync: width must be at least one");
	end

	a_sync_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		1'b1 ##2 1'b1 |-> stage2 == $past(port.raw, 2))
		else $error("synchroniser output not two cycles behind");
endmodule : sqtd_sync
`default_nettype wire

// *** sqtd_decoder.sv ***
// serial command decoder for driver tests and resistor diagnostics
`default_nettype none
module sqtd_decoder
	import sqtd_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic spi_clk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	output logic spi_miso_oe_out,
	input wire logic fire_enable_in_1,
	input wire logic fire_enable_in_2,
	input wire logic [1:0] fen_latch_in,
	input wire logic firing_in,
	input wire logic [2:0] rdiag_fault_in,
	input wire logic [2:0] rlim1_fault_in,
	input wire logic [2:0] rlim2_fault_in,
	input wire logic [3:0] high_drv_test_stat_in,
	input wire logic [3:0] low_drv_test_stat_in,
	output logic [7:0] fire_enable2_count_out,
	output logic [3:0] high_drv_on_out,
	output logic [3:0] low_drv_on_out
);
	localparam int SW = 24;

	// ************************************************************
	// link domain: receive on falling edge, send on rising edge
	// ************************************************************
	logic frame_rst_n;
	logic [3:0] rx_cnt;
	logic [6:0] rx_sh;
	logic [7:0] rx_byte;
	logic rx_tgl;
	logic [3:0] tx_cnt;
	logic [6:0] tx_sh;
	logic [7:0] resp;

	// a frame ends with chip select, so its counters need no edge after it
	assign frame_rst_n = rst_n_in & ~spi_cs_n_in;

	// bit counter and shifter restart at every frame
	always_ff @(negedge spi_clk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rx_cnt <= 4'h0;
			rx_sh <= 7'h00;
		end else if (rx_cnt != SPI_BITS) begin
			rx_cnt <= 4'(rx_cnt + 4'h1);
			rx_sh <= {rx_sh[5:0], spi_mosi_in};
		end
	end

	// whole byte handed over with a toggle; bits past eight are ignored
	always_ff @(negedge spi_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_byte <= 8'h00;
			rx_tgl <= 1'b0;
		end else if (rx_cnt == 4'h7) begin
			rx_byte <= {rx_sh, spi_mosi_in};
			rx_tgl <= ~rx_tgl;
		end
	end

	// answer of the previous byte leaves msb first
	always_ff @(posedge spi_clk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_cnt <= 4'h0;
			tx_sh <= 7'h00;
			spi_miso_out <= 1'b0;
			spi_miso_oe_out <= 1'b0;
		end else begin
			spi_miso_oe_out <= 1'b1;
			if (tx_cnt == 4'h0) begin
				spi_miso_out <= resp[7];
				tx_sh <= resp[6:0];
			end else begin
				spi_miso_out <= tx_sh[6];
				tx_sh <= {tx_sh[5:0], 1'b0};
			end
			if (tx_cnt != SPI_BITS) begin
				tx_cnt <= 4'(tx_cnt + 4'h1);
			end
		end
	end

	// ************************************************************
	// crossing into the system clock
	// ************************************************************
	sqtd_sync_if #(.W(SW)) sif ();

	logic cs_idle;
	logic tgl_s;
	logic tgl_d;
	logic fen1_s;
	logic fen2_s;
	logic [1:0] latch_s;
	logic firing;
	logic [2:0] rdiag_s;
	logic [2:0] rlim1_s;
	logic [2:0] rlim2_s;
	logic [3:0] hs_stat;
	logic [3:0] ls_stat;

	assign sif.raw = {spi_cs_n_in, rx_tgl, fire_enable_in_1,
		fire_enable_in_2, fen_latch_in, firing_in, rdiag_fault_in,
		rlim1_fault_in, rlim2_fault_in, high_drv_test_stat_in,
		low_drv_test_stat_in};
	assign {cs_idle, tgl_s, fen1_s, fen2_s, latch_s, firing, rdiag_s,
		rlim1_s, rlim2_s, hs_stat, ls_stat} = sif.clean;

	sqtd_sync #(.W(SW)) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.port(sif.sync)
	);

	// edge of the handed-over toggle marks one received byte
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tgl_d <= 1'b0;
		end else begin
			tgl_d <= tgl_s;
		end
	end

	// ************************************************************
	// command decode
	// ************************************************************
	sqtd_seq_t seq;
	sqtd_resp_t rmode;
	logic [7:0] resp_fix;
	logic byte_evt;
	logic follow;
	logic nop_evt;
	logic cnt_take;
	logic hs_take;
	logic ls_take;
	logic cmd_evt;
	logic [7:0] diag_byte;
	logic [7:0] next_resp;

	assign byte_evt = tgl_s ^ tgl_d;
	assign follow = byte_evt && (seq != ST_IDLE);
	// a firing driver turns any follow-on byte into nothing
	assign nop_evt = follow && firing;
	assign cnt_take = follow && !firing && (seq == ST_CNT);
	assign hs_take = follow && !firing && (seq == ST_HS) &&
		(rx_byte[7:4] == NIB_HS_TEST);
	assign ls_take = follow && !firing && (seq == ST_LS) &&
		(rx_byte[7:4] == NIB_LS_TEST);
	// anything else is read as a fresh command
	assign cmd_evt = byte_evt && !nop_evt && !cnt_take && !hs_take &&
		!ls_take;

	// an unlock is open for exactly one following frame
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seq <= ST_IDLE;
		end else if (byte_evt) begin
			if (cmd_evt && rx_byte == CMD_UNLOCK_CNT2) begin
				seq <= ST_CNT;
			end else if (cmd_evt && rx_byte == CMD_UNLOCK_HS) begin
				seq <= ST_HS;
			end else if (cmd_evt && rx_byte == CMD_UNLOCK_LS) begin
				seq <= ST_LS;
			end else begin
				seq <= ST_IDLE;
			end
		end
	end

	// second fire-enable count, msb in bit 7
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fire_enable2_count_out <= FIRE_ENABLE2_COUNT_RST;
		end else if (cnt_take) begin
			fire_enable2_count_out <= rx_byte;
		end
	end

	// test drives hold until the next byte; firing always drops them
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			high_drv_on_out <= 4'h0;
		end else if (firing) begin
			high_drv_on_out <= 4'h0;
		end else if (byte_evt) begin
			high_drv_on_out <= hs_take ? rx_byte[3:0] : 4'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_drv_on_out <= 4'h0;
		end else if (firing) begin
			low_drv_on_out <= 4'h0;
		end else if (byte_evt) begin
			low_drv_on_out <= ls_take ? rx_byte[3:0] : 4'h0;
		end
	end

	// choose what the next frame carries
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rmode <= RM_FIX;
			resp_fix <= RESP_NOP;
		end else if (byte_evt) begin
			rmode <= RM_FIX;
			resp_fix <= RESP_NOP;
			if (cnt_take) begin
				resp_fix <= rx_byte;
			end else if (hs_take) begin
				rmode <= RM_HS;
			end else if (ls_take) begin
				rmode <= RM_LS;
			end else if (cmd_evt) begin
				unique case (rx_byte)
					CMD_UNLOCK_CNT2, CMD_UNLOCK_HS, CMD_UNLOCK_LS: begin
						resp_fix <= rx_byte;
					end
					CMD_LINK_CHECK: begin
						resp_fix <= RESP_LINK_CHECK;
					end
					CMD_RES_DIAG: begin
						rmode <= RM_DIAG;
					end
					default: begin
						// reserved and foreign codes answer zero
						resp_fix <= RESP_NOP;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// answer word
	// ************************************************************

	// any of open, ground or supply makes a resistor bad
	always_comb begin
		diag_byte = 8'h00;
		diag_byte[DG_ONE] = 1'b1;
		diag_byte[DG_RLIM2_OK] = ~|rlim2_s;
		diag_byte[DG_RLIM1_OK] = ~|rlim1_s;
		diag_byte[DG_RDIAG_OK] = ~|rdiag_s;
		diag_byte[DG_LATCH2] = latch_s[1];
		diag_byte[DG_LATCH1] = latch_s[0];
		diag_byte[DG_FEN2] = fen2_s;
		diag_byte[DG_FEN1] = fen1_s;
	end

	always_comb begin
		unique case (rmode)
			RM_HS: next_resp = {NIB_ZERO, hs_stat};
			RM_LS: next_resp = {NIB_ZERO, ls_stat};
			RM_DIAG: next_resp = diag_byte;
			RM_FIX: next_resp = resp_fix;
		endcase
	end

	// live status tracks only while no frame runs, so the link side
	// reads a still word; the host keeps chip select high long enough
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			resp <= RESP_NOP;
		end else if (cs_idle) begin
			resp <= next_resp;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_resp_frozen: assert property (
		!cs_idle && $past(!cs_idle) |-> $stable(resp))
		else $error("answer changed during a frame");
	a_fire_nop: assert property (
		byte_evt && seq != ST_IDLE && firing |=>
		$stable(fire_enable2_count_out) && high_drv_on_out == 4'h0 &&
		low_drv_on_out == 4'h0 && resp_fix == RESP_NOP)
		else $error("follow-on byte acted while firing");
	a_seq_only: assert property (
		byte_evt && seq == ST_IDLE |=> high_drv_on_out == 4'h0 &&
		low_drv_on_out == 4'h0 && $stable(fire_enable2_count_out))
		else $error("test byte acted without unlock");
	a_cnt_load: assert property (
		cnt_take |=> fire_enable2_count_out == $past(rx_byte) &&
		rmode == RM_FIX && resp_fix == $past(rx_byte))
		else $error("second counter not loaded and echoed");
	a_hs_unlock: assert property (
		cmd_evt && rx_byte == CMD_UNLOCK_HS |=>
		seq == ST_HS && resp_fix == CMD_UNLOCK_HS)
		else $error("high-side unlock not armed or echoed");
	a_hs_drive: assert property (
		hs_take ##1 !firing |-> high_drv_on_out == $past(rx_byte[3:0])
		&& rmode == RM_HS)
		else $error("high-side drivers not set from test byte");
	a_hs_answer: assert property (
		rmode == RM_HS && cs_idle |=>
		resp == {NIB_ZERO, $past(hs_stat)})
		else $error("high-side test answer wrong");
	a_ls_unlock: assert property (
		cmd_evt && rx_byte == CMD_UNLOCK_LS |=>
		seq == ST_LS && resp_fix == CMD_UNLOCK_LS)
		else $error("low-side unlock not armed or echoed");
	a_ls_drive: assert property (
		ls_take ##1 !firing |-> low_drv_on_out == $past(rx_byte[3:0])
		&& rmode == RM_LS)
		else $error("low-side drivers not set from test byte");
	a_ls_answer: assert property (
		rmode == RM_LS && cs_idle |=>
		resp == {NIB_ZERO, $past(ls_stat)})
		else $error("low-side test answer wrong");
	a_link_check: assert property (
		cmd_evt && rx_byte == CMD_LINK_CHECK ##1 cs_idle [*2] |->
		resp == RESP_LINK_CHECK)
		else $error("link check not answered with complement");
	a_diag_layout: assert property (
		rmode == RM_DIAG && cs_idle |=> resp[DG_ONE] &&
		resp[DG_RDIAG_OK] == !$past(|rdiag_s) &&
		resp[DG_RLIM1_OK] == !$past(|rlim1_s) &&
		resp[DG_RLIM2_OK] == !$past(|rlim2_s) &&
		resp[DG_LATCH2:DG_LATCH1] == $past(latch_s) &&
		resp[DG_FEN1] == $past(fen1_s) &&
		resp[DG_FEN2] == $past(fen2_s))
		else $error("resistor diagnostic answer wrong");
	a_diag_fault: assert property (
		rmode == RM_DIAG && cs_idle && rlim1_s != 3'h0 |=>
		!resp[DG_RLIM1_OK])
		else $error("faulty current-limit resistor shown healthy");
	a_cnt_unlock: assert property (
		cmd_evt && rx_byte == CMD_UNLOCK_CNT2 |=>
		seq == ST_CNT && resp_fix == CMD_UNLOCK_CNT2)
		else $error("counter unlock not armed or echoed");

	c_cnt_prog: cover property (cnt_take);
	c_hs_test: cover property (hs_take ##[1:200] byte_evt);
	c_ls_test: cover property (ls_take);
	c_fire_nop: cover property (nop_evt);
endmodule : sqtd_decoder
`default_nettype wire

// *** sqtd_host.sv ***
// spi master model that plays the host microcontroller
`default_nettype none
module sqtd_host (
	output logic spi_clk_out,
	output logic spi_cs_n_out,
	output logic spi_mosi_out,
	input wire logic spi_miso_in,
	input wire logic spi_miso_oe_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// idle levels: link clock stands low outside frames
	// ************************************************************
	initial begin
		spi_clk_out = 1'b0;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = 1'b0;
	end

	// ************************************************************
	// one whole byte frame, 64 ns link clock, msb first
	// ************************************************************
	// data changes with the rising edge and is sampled on the falling one;
	// a bit seen while the answer driver is off reads as unknown
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int i;
		spi_cs_n_out = 1'b0;
		#150;
		for (i = 7; i >= 0; i--) begin
			spi_clk_out = 1'b1;
			spi_mosi_out = tx[i];
			#32;
			spi_clk_out = 1'b0;
			rx[i] = spi_miso_oe_in ? spi_miso_in : 1'bx;
			#32;
		end
		spi_cs_n_out = 1'b1;
		// a released data line must not keep showing its last bit
		spi_mosi_out = ~spi_mosi_out;
		#300;
	endtask : xfer

	// a frame cut off after nbits clocks; the device must drop it whole
	task automatic cut(input logic [7:0] tx, input int nbits);
		int i;
		spi_cs_n_out = 1'b0;
		#150;
		for (i = 7; i > 7 - nbits; i--) begin
			spi_clk_out = 1'b1;
			spi_mosi_out = tx[i];
			#32;
			spi_clk_out = 1'b0;
			#32;
		end
		spi_cs_n_out = 1'b1;
		spi_mosi_out = ~spi_mosi_out;
		#300;
	endtask : cut
endmodule : sqtd_host
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the squib test and diagnostic decoder
`default_nettype none
module testbench
	import sqtd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// signals, counters and the design
	// ************************************************************
	logic clk, rst_n, fen1, fen2, firing, sclk, cs_n, mosi, miso, oe;
	logic [1:0] latch;
	logic [2:0] rdf, r1f, r2f;
	logic [3:0] hs, ls, hon, lon, n;
	logic [7:0] cnt, rx, v;
	logic s;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	int i;

	sqtd_decoder u_dut (.clk_in(clk), .rst_n_in(rst_n),
		.spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
		.spi_miso_out(miso), .spi_miso_oe_out(oe),
		.fire_enable_in_1(fen1), .fire_enable_in_2(fen2),
		.fen_latch_in(latch), .firing_in(firing),
		.rdiag_fault_in(rdf), .rlim1_fault_in(r1f), .rlim2_fault_in(r2f),
		.high_drv_test_stat_in(hs), .low_drv_test_stat_in(ls),
		.fire_enable2_count_out(cnt), .high_drv_on_out(hon),
		.low_drv_on_out(lon));

	sqtd_host u_host (.spi_clk_out(sclk), .spi_cs_n_out(cs_n),
		.spi_mosi_out(mosi), .spi_miso_in(miso), .spi_miso_oe_in(oe));

	// 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// hang guard: the run needs a few thousand cycles at most
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic fr(input logic [7:0] tx);
		u_host.xfer(tx, rx);
	endtask : fr

	// random pin levels, then time for the two-flop synchronisers
	task automatic pins(input logic fire);
		@(negedge clk);
		{fen1, fen2, latch} = 4'($urandom);
		{rdf, r1f, r2f} = 9'($urandom);
		hs = 4'($urandom);
		ls = 4'($urandom);
		firing = fire;
		repeat (6) @(negedge clk);
	endtask : pins

	// resistor diagnostic answer expected from the pins now applied
	function automatic logic [7:0] diag_exp();
		return {1'b1, ~|r2f, ~|r1f, ~|rdf, latch, fen2, fen1};
	endfunction : diag_exp

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{rst_n, fen1, fen2, firing, latch, rdf, r1f, r2f, hs, ls} = '0;
		void'($urandom(32'h46BC9DFE));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk(cnt, FIRE_ENABLE2_COUNT_RST);
		chk({hon, lon}, 8'h00);
		$display("test reset done");

		// link check answered with its complement one frame later
		pins(1'b0);
		fr(CMD_LINK_CHECK);
		fr(CMD_LINK_CHECK);
		chk(rx, RESP_LINK_CHECK);
		$display("test link check done");

		// counter programming, all-ones first; random bytes only ever
		// follow an unlock, so no reserved code goes out as a command
		for (i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom);
			fr(CMD_UNLOCK_CNT2);
			fr(v);
			chk(rx, CMD_UNLOCK_CNT2);
			chk(cnt, v);
			fr(CMD_LINK_CHECK);
			chk(rx, v);
		end
		$display("test counter done");

		// driver tests, high and low side in turn, all channels first
		for (i = 0; i < 8; i++) begin
			s = i[0];
			n = (i < 2) ? 4'hF : 4'($urandom);
			pins(1'b0);
			fr(s ? CMD_UNLOCK_LS : CMD_UNLOCK_HS);
			fr({s ? NIB_LS_TEST : NIB_HS_TEST, n});
			chk(rx, s ? CMD_UNLOCK_LS : CMD_UNLOCK_HS);
			chk({hon, lon}, s ? {4'h0, n} : {n, 4'h0});
			fr(CMD_LINK_CHECK);
			chk(rx, {NIB_ZERO, s ? ls : hs});
		end
		$display("test driver done");

		// an intervening frame cancels the unlock
		pins(1'b0);
		hs = 4'h5;
		fr(CMD_UNLOCK_HS);
		fr(CMD_LINK_CHECK);
		fr({NIB_HS_TEST, 4'hF});
		chk({4'h0, hon}, 8'h00);
		fr(CMD_LINK_CHECK);
		chk(rx, RESP_NOP);
		$display("test broken pair done");

		// a firing driver drops test drives and voids follow-on bytes
		fr(CMD_UNLOCK_HS);
		fr({NIB_HS_TEST, 4'hF});
		chk({hon, lon}, 8'hF0);
		pins(1'b1);
		chk({hon, lon}, 8'h00);
		fr(CMD_UNLOCK_CNT2);
		fr(~v);
		chk(cnt, v);
		fr(CMD_UNLOCK_HS);
		chk(rx, RESP_NOP);
		fr({NIB_HS_TEST, 4'hF});
		chk(rx, CMD_UNLOCK_HS);
		chk({hon, lon}, 8'h00);
		fr(CMD_LINK_CHECK);
		chk(rx, RESP_NOP);
		pins(1'b0);
		$display("test firing done");

		// a frame cut short is dropped, so the last answer still stands
		fr(CMD_LINK_CHECK);
		u_host.cut(CMD_UNLOCK_CNT2, 7);
		fr(8'h5A);
		chk(rx, RESP_LINK_CHECK);
		chk(cnt, v);
		$display("test cut frame done");

		// resistor diagnostic: each fault kind alone, none, then random
		for (i = 0; i < 8; i++) begin
			pins(1'b0);
			if (i < 3)
				{rdf, r1f, r2f} = {3{3'h1 << i}};
			if (i == 3)
				{rdf, r1f, r2f} = 9'h000;
			repeat (6) @(negedge clk);
			fr(CMD_RES_DIAG);
			fr(CMD_LINK_CHECK);
			chk(rx, diag_exp());
			chk(rx & 8'h03, {6'h00, fen2, fen1});
		end
		$display("test diagnostic done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
